// File: bench/flash_seq_checker.sv
// Port assertions for the flash row sequencer
`include "flash_seq_cfg.svh"
module flash_seq_checker
#(
  parameter int ERASE_CYC = 20,
  parameter int PROG_CYC  = 20
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        core_stall_o,
  input wire logic        flash_erase_o,
  input wire logic        flash_prog_o
);
  // ****************************************
  // Helper state: run length and key history
  // ****************************************
  logic [7:0] run_reg, run_next;
  logic       ers_reg, ers_next, aa_reg, aa_next, k1_reg, k1_next, k2_reg, k2_next, arm_reg, arm_next;
  logic       take_wr, key_ok;

  always_comb
  begin
    take_wr  = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
    run_next = (core_stall_o && !rst_i) ? run_reg + 8'h01 : 8'h00;
    ers_next = core_stall_o & !rst_i & (ers_reg | flash_erase_o);
    aa_next  = take_wr ? (wb_adr_i == `FS_KEY_OFS && wb_dat_i[7:0] == `FS_KEY_SECOND) : aa_reg;
    k1_next  = take_wr ? (wb_adr_i == `FS_KEY_OFS && wb_dat_i[7:0] == `FS_KEY_FIRST) : k1_reg;
    k2_next  = take_wr ? k1_reg : k2_reg;
    arm_next = arm_reg;
    if (take_wr && wb_adr_i == `FS_CONTROL_OFS && wb_sel_i[1:0] == 2'b11 && !core_stall_o)
      arm_next = wb_dat_i[`FS_ARM_BIT] && wb_dat_i[5:0] == `FS_OP_ROW;
    if (rst_i)
      {aa_next, k1_next, k2_next, arm_next} = 4'h0;
    key_ok = aa_reg & k2_reg & arm_reg;
  end

  always_ff @(posedge clk_i)
  begin
    {run_reg, ers_reg, aa_reg, k1_reg, k2_reg, arm_reg} <= {run_next, ers_next, aa_next, k1_next, k2_next, arm_next};
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence start_open;
    take_wr && wb_adr_i == `FS_CONTROL_OFS && wb_dat_i[`FS_START_BIT] && !core_stall_o && key_ok;
  endsequence
  sequence start_shut;
    take_wr && wb_adr_i == `FS_CONTROL_OFS && wb_dat_i[`FS_START_BIT] && !core_stall_o && !key_ok;
  endsequence
  sequence run_begins;
    ##[1:3] core_stall_o;
  endsequence

  ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  unlock_start_a: assert property (start_open |-> run_begins)
    else $error("unlocked start did not launch");
  locked_start_a: assert property (start_shut |=> !core_stall_o [*3])
    else $error("start launched without unlock");
  erase_len_a: assert property ($fell(core_stall_o) && ers_reg |-> int'(run_reg) == ERASE_CYC)
    else $error("erase stall length wrong");
  prog_len_a: assert property ($fell(core_stall_o) && !ers_reg |-> int'(run_reg) == PROG_CYC)
    else $error("program stall length wrong");
  strobe_in_stall_a: assert property ((flash_erase_o || flash_prog_o) |-> core_stall_o && !(flash_erase_o && flash_prog_o))
    else $error("flash strobe outside stall");
endmodule : flash_seq_checker

// File: bench/flash_sw_model.sv
// Core software model issuing register and table writes over Wishbone
`include "flash_seq_cfg.svh"
module flash_sw_model
(
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic        core_stall_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] exp_q[$];
  logic [23:0] op_q[$];

  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end

  // ****************************************
  // Bus cycles and the unlock sequence
  // ****************************************
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'b11, we, a, 4'hf, d};
    n = 0;
    // Ack is sampled on the rising edge only; the request stands until then
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_i !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      tb.num_errors++;
      tb.end_of_test();
    end
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic run_op(input logic [15:0] ctl, input logic [23:0] row);
    int n;
    op_q.push_back(row);
    // Keys and start go out with nothing between, as with interrupts held
    wr(`FS_KEY_OFS, 32'h0000_0055);
    wr(`FS_KEY_OFS, 32'h0000_00aa);
    wr(`FS_CONTROL_OFS, {16'h0000, ctl | 16'h8000});
    repeat (2) @(negedge clk_i);
    n = 0;
    while (core_stall_i !== 1'b0 && n < 1000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 1000)
    begin
      tb.num_errors++;
      tb.end_of_test();
    end
  endtask : run_op
endmodule : flash_sw_model

// File: bench/tb.sv
// Self-checking testbench for the flash row sequencer
`include "flash_seq_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ERASE_N = 20;
  localparam int PROG_N  = 40;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, core_stall_o, stall_last;
  logic [7:0]  wb_adr_i, pg;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, w;
  logic        flash_erase_o, flash_prog_o;
  logic [23:0] flash_row_addr_o, row_seen, row;
  logic [23:0] flash_wdata_o, wdata_q[$];
  int          stb_cnt, cnt_q[$];
  logic [15:0] ofs;
  int          num_errors, total_checks, seed;

  flash_row_erase_program #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_stall_o(core_stall_o),
    .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o), .flash_row_addr_o(flash_row_addr_o),
    .flash_wdata_o(flash_wdata_o));
  flash_sw_model sw (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .core_stall_i(core_stall_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));

  task cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task cmp_row(input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch row address expected %h seen %h", exp, got);
    end
  endtask : cmp_row

  task end_of_test;
    if (sw.exp_q.size() != 0 || sw.op_q.size() != 0 || wdata_q.size() != 0 || cnt_q.size() != 0)
      num_errors++;
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ****************************************
  // Result watcher: oldest note against each answer
  // ****************************************
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      cmp_word("read data", sw.exp_q.pop_front(), wb_dat_o);
    if (flash_prog_o === 1'b1 && wdata_q.size() > 0)
      cmp_word("program word", {8'h00, wdata_q.pop_front()}, {8'h00, flash_wdata_o});
    if (core_stall_o === 1'b1 && stall_last !== 1'b1)
    begin
      row_seen <= flash_row_addr_o;
      stb_cnt  <= 0;
    end
    else if (flash_erase_o === 1'b1 || flash_prog_o === 1'b1)
      stb_cnt <= stb_cnt + 1;
    if (core_stall_o === 1'b0 && stall_last === 1'b1)
    begin
      cmp_row(sw.op_q.pop_front(), row_seen);
      cmp_word("strobe cycles", 32'(cnt_q.pop_front()), 32'(stb_cnt));
    end
    stall_last <= core_stall_o;
  end

  initial
  begin
    seed = 32'he911;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    sw.rd(`FS_CONTROL_OFS, {16'h0000, `FS_CONTROL_RST});
    sw.rd(`FS_STATUS_OFS, 32'h0000_0000);
    sw.rd(8'h1c, 32'h0000_0000);
    sw.wr(8'h1c, 32'hffff_ffff);
    sw.rd(`FS_KEY_OFS, 32'h0000_0000);
    sw.wr(`FS_CONTROL_OFS, 32'h0000_4058);
    sw.wr(`FS_PAGE_OFS, 32'h0000_0005);
    sw.wr(`FS_OFFSET_OFS, 32'h0000_0240);
    sw.wr(`FS_LATCH_LOW_OFS, 32'h0000_0240);
    cnt_q.push_back(ERASE_N - 1);
    sw.run_op(16'h4058, 24'h050240);
    sw.rd(`FS_CONTROL_OFS, 32'h0000_4058);
    sw.rd(`FS_STATUS_OFS, 32'h0000_0004);
    // Wrong key, a foreign write after the keys, then start without arm
    sw.wr(`FS_KEY_OFS, 32'h55); sw.wr(`FS_KEY_OFS, 32'h12); sw.wr(`FS_KEY_OFS, 32'haa);
    sw.wr(`FS_CONTROL_OFS, 32'h0000_c058);
    sw.wr(`FS_KEY_OFS, 32'h55); sw.wr(`FS_KEY_OFS, 32'haa); sw.wr(`FS_PAGE_OFS, 32'h05);
    sw.wr(`FS_CONTROL_OFS, 32'h0000_c058);
    // A start between the two keys must also drop the first key
    sw.wr(`FS_KEY_OFS, 32'h55); sw.wr(`FS_CONTROL_OFS, 32'h0000_c058);
    sw.wr(`FS_KEY_OFS, 32'haa); sw.wr(`FS_CONTROL_OFS, 32'h0000_c058);
    sw.rd(`FS_CONTROL_OFS, 32'h0000_4058);
    sw.wr(`FS_CONTROL_OFS, 32'h0000_0058);
    sw.wr(`FS_KEY_OFS, 32'h55); sw.wr(`FS_KEY_OFS, 32'haa); sw.wr(`FS_CONTROL_OFS, 32'h0000_8058);
    sw.rd(`FS_CONTROL_OFS, 32'h0000_0058);
    // Row program at a random row; low words carry the in-row address so either index reading holds
    pg = 8'($random(seed));
    ofs = 16'($random(seed)) & 16'hffc0;
    row = {pg, ofs[15:6], 6'h00};
    sw.wr(`FS_CONTROL_OFS, 32'h0000_4018);
    sw.wr(`FS_PAGE_OFS, {24'h000000, pg});
    sw.wr(`FS_OFFSET_OFS, {16'h0000, ofs});
    for (int i = 0; i < `FS_ROW_WORDS; i++)
    begin
      w = $random(seed);
      sw.wr(`FS_LATCH_LOW_OFS, {16'h0000, ofs | 16'(i * 2)});
      sw.wr(`FS_LATCH_HIGH_OFS, {24'h000000, w[7:0]});
      wdata_q.push_back({w[7:0], ofs | 16'(i * 2)});
    end
    cnt_q.push_back(PROG_N - 1);
    sw.run_op(16'h4018, row);
    sw.rd(`FS_CONTROL_OFS, 32'h0000_4018);
    // Let the watcher take the last answer before the verdict
    repeat (2) @(posedge clk_i);
    end_of_test();
  end
endmodule : tb

bind flash_row_erase_program flash_seq_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .core_stall_o(core_stall_o), .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o));

// File: pkg/flash_seq_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash row sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// Register byte offsets
`define FS_CONTROL_OFS      8'h00
`define FS_KEY_OFS          8'h04
`define FS_PAGE_OFS         8'h08
`define FS_OFFSET_OFS       8'h0c
`define FS_LATCH_LOW_OFS    8'h10
`define FS_LATCH_HIGH_OFS   8'h14
`define FS_STATUS_OFS       8'h18

// Control field positions
`define FS_OP_LSB           0
`define FS_OP_MSB           5
`define FS_ERASE_BIT        6
`define FS_ARM_BIT          14
`define FS_START_BIT        15

// Values
`define FS_OP_ROW           6'h18
`define FS_KEY_FIRST        8'h55
`define FS_KEY_SECOND       8'haa
`define FS_CONTROL_RST      16'h0000
`define FS_ROW_WORDS        32

// Cycle times at 10 MHz
`define FS_CLK_NS           100
`define FS_ERASE_NS         200000
`define FS_PROG_NS          200000
`define FS_ERASE_CYC        ((`FS_ERASE_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`define FS_PROG_CYC         ((`FS_PROG_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)

`endif

// File: pkg/flash_seq_pkg.sv
// Types shared by the flash row sequencer
package flash_seq_pkg;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_UNLOCKED} key_state_e;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ERASE, SEQ_PROGRAM} seq_state_e;
endpackage : flash_seq_pkg

// File: rtl/flash_row_erase_program.sv
// Flash row erase and program sequencer with a classic Wishbone register slave
// Operation
// - Row erase uses op 011000, erase, arm
// - Keys 55h then AAh before start
// - Start bit launches; hardware clears it after
// - Core stalled during whole erase cycle
// - Operations act on one 32-word row
// - Software fills 32 latches, low/high post-increment
// - Program uses op 011000, erase clear, arm
// - Core stalled during program, then start clears
//
// Decided for this implementation: register access over Wishbone and the address map.
`include "flash_seq_cfg.svh"
module flash_row_erase_program
#(
  parameter int ROW_WORDS  = `FS_ROW_WORDS,
  parameter int ERASE_CYC  = `FS_ERASE_CYC,
  parameter int PROG_CYC   = `FS_PROG_CYC,
  parameter int ADDR_W     = 24
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   core_stall_o,
  output logic                   flash_erase_o,
  output logic                   flash_prog_o,
  output logic      [ADDR_W-1:0] flash_row_addr_o,
  output logic      [23:0]       flash_wdata_o
);

  localparam int IDX_W = $clog2(ROW_WORDS);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        req;
  logic        wr;
  logic        lo_en;
  logic [15:0] wdat;
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i;
  assign lo_en = wb_sel_i[0] && wb_sel_i[1];
  assign wdat  = wb_dat_i[15:0];

  function automatic logic hit(input logic [7:0] ofs);
    hit = (wb_adr_i == ofs);
  endfunction : hit

  logic wr_ctl;
  logic wr_key;
  logic wr_page;
  logic wr_ofs;
  logic wr_lo;
  logic wr_hi;
  assign wr_ctl  = wr && hit(`FS_CONTROL_OFS) && lo_en;
  assign wr_key  = wr && hit(`FS_KEY_OFS) && wb_sel_i[0];
  assign wr_page = wr && hit(`FS_PAGE_OFS) && wb_sel_i[0];
  assign wr_ofs  = wr && hit(`FS_OFFSET_OFS) && lo_en;
  assign wr_lo   = wr && hit(`FS_LATCH_LOW_OFS) && lo_en;
  assign wr_hi   = wr && hit(`FS_LATCH_HIGH_OFS) && wb_sel_i[0];

  // ****************************************************************
  // State
  // ****************************************************************
  flash_seq_pkg::seq_state_e state_reg;
  flash_seq_pkg::seq_state_e state_next;
  logic [15:0]       ctl_reg;
  logic [15:0]       ctl_next;
  logic [7:0]        page_reg;
  logic [7:0]        page_next;
  logic [15:0]       ofs_reg;
  logic [15:0]       ofs_next;
  logic [IDX_W-1:0]  idx_reg;
  logic [IDX_W-1:0]  idx_next;
  logic [31:0]       cnt_reg;
  logic [31:0]       cnt_next;
  logic [IDX_W-1:0]  word_reg;
  logic [IDX_W-1:0]  word_next;
  logic              stall_reg;
  logic              stall_next;
  logic              erase_reg;
  logic              erase_next;
  logic              prog_reg;
  logic              prog_next;
  logic [31:0]       rdat_reg;
  logic [31:0]       rdat_next;
  logic              ack_reg;
  logic              ack_next;
  logic              done_reg;
  logic              done_next;
  logic              unlocked;
  logic [23:0]       latch_word;
  logic              start_req;

  // A start write is any control write with the start bit set
  assign start_req = wr_ctl && wdat[`FS_START_BIT];

  flash_unlock u_unlock
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .key_wr_i   (wr_key),
    .key_data_i (wdat[7:0]),
    .other_wr_i (wr && !hit(`FS_KEY_OFS) && !start_req),
    .start_wr_i (start_req),
    .unlocked_o (unlocked)
  );

  flash_row_latch #(.ROW_WORDS(ROW_WORDS)) u_latch
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .index_i    (idx_reg),
    .low_wr_i   (wr_lo),
    .high_wr_i  (wr_hi),
    .data_i     (wdat),
    .rd_index_i (word_reg),
    .rd_word_o  (latch_word)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    ctl_next   = ctl_reg;
    page_next  = page_reg;
    ofs_next   = ofs_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    word_next  = word_reg;
    erase_next = 1'b0;
    prog_next  = 1'b0;
    done_next  = done_reg;
    ack_next   = req;
    rdat_next  = 32'h00000000;

    if (wr_page)
      page_next = wdat[7:0];
    if (wr_ofs)
      ofs_next = wdat;
    // Dummy low write latches the row base and points the index at the word
    if (wr_lo)
      ofs_next = wdat;
    if (wr_ofs || (wr_lo && state_reg == flash_seq_pkg::SEQ_IDLE && !ctl_reg[`FS_START_BIT]))
      idx_next = wdat[IDX_W:1];
    if (wr_hi)
      idx_next = idx_reg + 1'b1;

    case (state_reg)
      flash_seq_pkg::SEQ_IDLE:
      begin
        if (wr_ctl)
        begin
          ctl_next = {1'b0, wdat[14:0]};
          if (start_req && unlocked && ctl_reg[`FS_ARM_BIT]
              && ctl_reg[`FS_OP_MSB:`FS_OP_LSB] == `FS_OP_ROW)
          begin
            ctl_next[`FS_START_BIT] = 1'b1;
            cnt_next  = 32'h00000000;
            word_next = '0;
            done_next = 1'b0;
            // Erase bit picks erase over program; op code is the same
            if (ctl_reg[`FS_ERASE_BIT])
              state_next = flash_seq_pkg::SEQ_ERASE;
            else
              state_next = flash_seq_pkg::SEQ_PROGRAM;
          end
        end
      end
      flash_seq_pkg::SEQ_ERASE:
      begin
        erase_next = 1'b1;
        cnt_next   = cnt_reg + 32'h00000001;
        if (cnt_reg == 32'(ERASE_CYC - 1))
        begin
          ctl_next[`FS_START_BIT] = 1'b0;
          erase_next = 1'b0;
          done_next  = 1'b1;
          state_next = flash_seq_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        // One latch word is offered per cycle for the first ROW_WORDS cycles, then the last word is held
        prog_next  = 1'b1;
        cnt_next   = cnt_reg + 32'h00000001;
        if (word_reg != IDX_W'(ROW_WORDS - 1))
          word_next = word_reg + 1'b1;
        if (cnt_reg == 32'(PROG_CYC - 1))
        begin
          ctl_next[`FS_START_BIT] = 1'b0;
          prog_next  = 1'b0;
          done_next  = 1'b1;
          state_next = flash_seq_pkg::SEQ_IDLE;
        end
      end
    endcase

    // Core stays stalled from the start write until the cycle ends
    stall_next = (state_next != flash_seq_pkg::SEQ_IDLE);

    if (req && !wb_we_i)
    begin
      if (hit(`FS_CONTROL_OFS))
        rdat_next = {16'h0000, ctl_reg};
      else if (hit(`FS_PAGE_OFS))
        rdat_next = {24'h000000, page_reg};
      else if (hit(`FS_OFFSET_OFS))
        rdat_next = {16'h0000, ofs_reg};
      else if (hit(`FS_STATUS_OFS))
        // Index sits just above the three flag bits
        rdat_next = {24'h000000, 8'({idx_reg, done_reg, unlocked, stall_reg})};
      else
        rdat_next = 32'h00000000;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= flash_seq_pkg::SEQ_IDLE;
      ctl_reg   <= `FS_CONTROL_RST;
      page_reg  <= 8'h00;
      ofs_reg   <= 16'h0000;
      idx_reg   <= '0;
      cnt_reg   <= 32'h00000000;
      word_reg  <= '0;
      stall_reg <= 1'b0;
      erase_reg <= 1'b0;
      prog_reg  <= 1'b0;
      rdat_reg  <= 32'h00000000;
      ack_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ctl_reg   <= ctl_next;
      page_reg  <= page_next;
      ofs_reg   <= ofs_next;
      idx_reg   <= idx_next;
      cnt_reg   <= cnt_next;
      word_reg  <= word_next;
      stall_reg <= stall_next;
      erase_reg <= erase_next;
      prog_reg  <= prog_next;
      rdat_reg  <= rdat_next;
      ack_reg   <= ack_next;
      done_reg  <= done_next;
    end
  end

  logic [ADDR_W-1:0] row_addr_reg;
  logic [23:0]       wdata_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      row_addr_reg <= '0;
      wdata_reg    <= 24'h000000;
    end
    else
    begin
      // Row base: low offset bits inside the row are forced to zero
      row_addr_reg <= ADDR_W'({page_reg, ofs_reg[15:IDX_W+1], {(IDX_W+1){1'b0}}});
      wdata_reg    <= latch_word;
    end
  end

  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = rdat_reg;
  assign core_stall_o     = stall_reg;
  assign flash_erase_o    = erase_reg;
  assign flash_prog_o     = prog_reg;
  assign flash_row_addr_o = row_addr_reg;
  assign flash_wdata_o    = wdata_reg;

endmodule : flash_row_erase_program

// File: rtl/flash_row_latch.sv
// Row write latches: 32 words of low 16 bits and high 8 bits, indexed storage
`include "flash_seq_cfg.svh"
module flash_row_latch
#(
  parameter int ROW_WORDS = `FS_ROW_WORDS
)
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic [$clog2(ROW_WORDS)-1:0] index_i,
  input  wire logic                         low_wr_i,
  input  wire logic                         high_wr_i,
  input  wire logic [15:0]                  data_i,
  input  wire logic [$clog2(ROW_WORDS)-1:0] rd_index_i,
  output logic      [23:0]                  rd_word_o
);

  logic [23:0] mem_reg  [ROW_WORDS];
  logic [23:0] mem_next [ROW_WORDS];

  always_comb
  begin
    for (int i = 0; i < ROW_WORDS; i++)
      mem_next[i] = mem_reg[i];
    if (low_wr_i)
      mem_next[index_i][15:0] = data_i;
    if (high_wr_i)
      mem_next[index_i][23:16] = data_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < ROW_WORDS; i++)
      mem_reg[i] <= rst_i ? 24'hffffff : mem_next[i];
  end

  assign rd_word_o = mem_reg[rd_index_i];

endmodule : flash_row_latch

// File: rtl/flash_unlock.sv
// Two-key unlock tracker for the flash control start bit
`include "flash_seq_cfg.svh"
module flash_unlock
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       key_wr_i,
  input  wire logic [7:0] key_data_i,
  input  wire logic       other_wr_i,
  input  wire logic       start_wr_i,
  output logic            unlocked_o
);

  flash_seq_pkg::key_state_e state_reg;
  flash_seq_pkg::key_state_e state_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      flash_seq_pkg::KEY_IDLE:
      begin
        if (key_wr_i && key_data_i == `FS_KEY_FIRST)
          state_next = flash_seq_pkg::KEY_GOT_FIRST;
      end
      flash_seq_pkg::KEY_GOT_FIRST:
      begin
        if (key_wr_i && key_data_i == `FS_KEY_SECOND)
          state_next = flash_seq_pkg::KEY_UNLOCKED;
        else if (key_wr_i || other_wr_i || start_wr_i)
          state_next = flash_seq_pkg::KEY_IDLE;
      end
      default:
      begin
        // Any write after the keys, start or not, consumes the unlock
        if (key_wr_i || other_wr_i || start_wr_i)
          state_next = flash_seq_pkg::KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= flash_seq_pkg::KEY_IDLE;
    else
      state_reg <= state_next;
  end

  assign unlocked_o = (state_reg == flash_seq_pkg::KEY_UNLOCKED);

endmodule : flash_unlock
